// ---- inc/pld_pkg.sv ----
// Shared constants, types and helpers for the programmable logic group
package pld_pkg;

  localparam int NUM_MC = 16;
  localparam int NUM_ROUTE = 36;
  localparam int NUM_DED = 4;
  localparam int NUM_PT = 5;
  localparam int MAX_PT = 32;
  localparam int BUS_W = NUM_ROUTE + NUM_DED;
  localparam int ARR_W = BUS_W + NUM_MC;
  localparam int NUM_TERMS = NUM_MC * NUM_PT;
  localparam int ADDR_W = 16;

  localparam logic [ARR_W-1:0] BUS_MASK = 56'h00_0000_FFFF_FFFF_FF;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_MC_BASE = 16'h0100;
  localparam logic [ADDR_W-1:0] ADDR_PT_BASE = 16'h1000;
  localparam logic [ADDR_W-1:0] ADDR_PT_END = 16'h1500;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_GP_LSB = 1;
  localparam int CTRL_GC0_SRC = 5;
  localparam int CTRL_GC0_INV = 6;
  localparam int CTRL_GC1_SRC = 7;
  localparam int CTRL_GC1_INV = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  localparam int MC_FF_LSB = 0;
  localparam int MC_BYPASS = 2;
  localparam int MC_CKM_LSB = 3;
  localparam int MC_GCSEL = 5;
  localparam int MC_GCLR = 6;
  localparam int MC_FAST = 7;
  localparam int MC_POL = 8;
  localparam int MC_SEL_LSB = 9;
  localparam int MC_CFG_W = 24;
  localparam logic [MC_CFG_W-1:0] MC_CFG_RESET = 24'h00_0000;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_t;
  typedef enum logic [1:0] {CK_GLOBAL, CK_GATED, CK_ARRAY} ckm_t;
  typedef enum logic [2:0] {
    PT_OFF, PT_OR, PT_CLR, PT_PRE, PT_CLK, PT_CEN, PT_EXP
  } ptsel_t;
  typedef enum logic [2:0] {R_NONE, R_CTRL, R_STAT, R_MC, R_PT} region_t;

  // A term with no literal programmed is treated as unused, i.e. low
  function automatic logic pt_eval(input logic [ARR_W-1:0] tm,
                                   input logic [ARR_W-1:0] cm,
                                   input logic [ARR_W-1:0] v);
    pt_eval = (|(tm | cm)) & (&(~tm | v)) & (&(~cm | ~v));
  endfunction

endpackage

// ---- rtl/pld_macrocell.sv ----
// One macrocell: product terms, select matrix and programmable register
`timescale 1ns/100ps
module pld_macrocell
  import pld_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [pld_pkg::MC_CFG_W-1:0] i_cfg,
  input wire logic [pld_pkg::NUM_PT*pld_pkg::ARR_W-1:0] i_tmask,
  input wire logic [pld_pkg::NUM_PT*pld_pkg::ARR_W-1:0] i_cmask,
  input wire logic [pld_pkg::ARR_W-1:0] i_arr,
  input wire logic [1:0] i_gclk_tick,
  input wire logic i_gclr_low,
  input wire logic i_fast_pin,
  output logic o_out,
  output logic o_exp
);
  import pld_pkg::*;

  function automatic ptsel_t term_sel(input logic [MC_CFG_W-1:0] c,
                                      input int idx);
    term_sel = ptsel_t'(c[MC_SEL_LSB+3*idx +: 3]);
  endfunction

  logic [NUM_PT-1:0] pt;
  logic [NUM_PT-1:0] pt_bus;
  logic set_sum, rst_sum, clr, pre, clk_pt, cen, comb, nxt, tick;
  logic q_q, aclk_q;
  ff_t ff_type;
  ckm_t ckm;

  assign ff_type = ff_t'(i_cfg[MC_FF_LSB +: 2]);
  assign ckm = ckm_t'(i_cfg[MC_CKM_LSB +: 2]);

  // Five dedicated product terms per cell
  genvar g;
  generate
    for (g = 0; g < NUM_PT; g++) begin : g_pt
      assign pt[g] = pt_eval(i_tmask[g*ARR_W +: ARR_W],
                             i_cmask[g*ARR_W +: ARR_W], i_arr);
      // Expander sees only bus lines, so expanders never loop back
      assign pt_bus[g] = pt_eval(i_tmask[g*ARR_W +: ARR_W] & BUS_MASK,
                                 i_cmask[g*ARR_W +: ARR_W] & BUS_MASK,
                                 i_arr);
    end
  endgenerate

  // Select matrix: each term to logic, to one register control or to the expander output
  always_comb begin
    set_sum = 1'b0;
    rst_sum = 1'b0;
    clr = 1'b0;
    pre = 1'b0;
    clk_pt = 1'b0;
    cen = 1'b0;
    o_exp = 1'b0;
    for (int i = 0; i < NUM_PT; i++) begin
      case (term_sel(i_cfg, i))
        PT_OR: begin
          if (i < 3) set_sum = set_sum | pt[i];
          else rst_sum = rst_sum | pt[i];
        end
        PT_CLR: clr = clr | pt[i];
        PT_PRE: pre = pre | pt[i];
        PT_CLK: clk_pt = clk_pt | pt[i];
        PT_CEN: cen = cen | pt[i];
        PT_EXP: o_exp = o_exp | pt_bus[i];
        default: ;
      endcase
    end
    // Global clear pin is active low and acts only in cells that set MC_GCLR
    clr = clr | (i_cfg[MC_GCLR] & ~i_gclr_low);
  end

  assign comb = (set_sum | rst_sum) ^ i_cfg[MC_POL];

  // Flip-flop personality; JK and SR take set terms 0-2, reset 3-4
  always_comb begin
    case (ff_type)
      FF_D: nxt = (i_cfg[MC_FAST]) ? i_fast_pin : comb;
      FF_T: nxt = q_q ^ comb;
      FF_JK: nxt = (set_sum & ~q_q) | (~rst_sum & q_q);
      FF_SR: nxt = set_sum | (~rst_sum & q_q);
      default: nxt = q_q;
    endcase
  end

  // Three clock sources, each reduced to an enable on i_mclk
  always_comb begin
    case (ckm)
      CK_GLOBAL: tick = i_gclk_tick[i_cfg[MC_GCSEL]];
      CK_GATED: tick = i_gclk_tick[i_cfg[MC_GCSEL]] & cen;
      CK_ARRAY: tick = clk_pt & ~aclk_q;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) aclk_q <= 1'b0;
    else aclk_q <= clk_pt;
  end

  // Clear and preset act without waiting for a tick; clear wins
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_run) q_q <= 1'b0;
    else if (clr) q_q <= 1'b0;
    else if (pre) q_q <= 1'b1;
    else if (tick) q_q <= nxt;
  end

  assign o_out = i_cfg[MC_BYPASS] ? comb : q_q;

endmodule

// ---- rtl/pld_logic_group.sv ----
// Logic group of sixteen macrocells with APB configuration port
`timescale 1ns/100ps
module pld_logic_group
  import pld_pkg::*;
#(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pld_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [pld_pkg::NUM_ROUTE-1:0] i_global_routing_bus,
  input wire logic i_global_clock_pin_a,
  input wire logic i_global_clock_pin_b,
  input wire logic i_global_clear_low,
  input wire logic i_oe_low,
  input wire logic [pld_pkg::NUM_MC-1:0] i_pin,
  output logic [pld_pkg::NUM_MC-1:0] o_mc_out,
  output logic [1:0] o_oe
);
  import pld_pkg::*;

  localparam int SYNC_W = NUM_ROUTE + NUM_DED + NUM_MC;

  function automatic region_t region_of(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) region_of = R_NONE;
    else if (a == ADDR_CTRL) region_of = R_CTRL;
    else if (a == ADDR_STAT) region_of = R_STAT;
    else if (a >= ADDR_MC_BASE &&
             a < ADDR_MC_BASE + 16'(NUM_MC * 4)) region_of = R_MC;
    else if (a >= ADDR_PT_BASE && a < ADDR_PT_END) region_of = R_PT;
    else region_of = R_NONE;
  endfunction

  // Pin side inputs cross into i_mclk through two flip-flops
  logic [SYNC_W-1:0] meta_q, sync_q;
  logic [NUM_ROUTE-1:0] route_s;
  logic [NUM_DED-1:0] ded_s, ded_prev_q;
  logic [NUM_MC-1:0] pin_s;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_pin, i_oe_low, i_global_clear_low,
                 i_global_clock_pin_b, i_global_clock_pin_a,
                 i_global_routing_bus};
      sync_q <= meta_q;
    end
  end

  assign route_s = sync_q[NUM_ROUTE-1:0];
  assign ded_s = sync_q[BUS_W-1:NUM_ROUTE];
  assign pin_s = sync_q[SYNC_W-1:BUS_W];

  always_ff @(posedge i_mclk) begin
    if (i_srst) ded_prev_q <= '0;
    else ded_prev_q <= ded_s;
  end

  // Configuration storage
  logic [CTRL_W-1:0] ctrl_q;
  logic [MC_CFG_W-1:0] mc_cfg_q [NUM_MC];
  logic [ARR_W-1:0] pt_true_q [NUM_TERMS];
  logic [ARR_W-1:0] pt_comp_q [NUM_TERMS];
  logic running;
  logic [NUM_DED-1:0] gp_mode;

  assign running = ctrl_q[CTRL_RUN];
  assign gp_mode = ctrl_q[CTRL_GP_LSB +: NUM_DED];

  // Dedicated line 0 clock a, 1 clock b or second enable, 2 clear, 3 enable
  logic [1:0] gclk_tick;
  logic gclr_low;
  logic [NUM_DED-1:0] ded_rise, ded_fall;

  assign ded_rise = ded_s & ~ded_prev_q;
  assign ded_fall = ~ded_s & ded_prev_q;

  // Global clocks become one-cycle enables on i_mclk
  always_comb begin
    if (EXTENDED) begin
      gclk_tick[0] = ctrl_q[CTRL_GC0_INV] ?
                     ded_fall[ctrl_q[CTRL_GC0_SRC]] :
                     ded_rise[ctrl_q[CTRL_GC0_SRC]];
      gclk_tick[1] = ctrl_q[CTRL_GC1_INV] ?
                     ded_fall[ctrl_q[CTRL_GC1_SRC]] :
                     ded_rise[ctrl_q[CTRL_GC1_SRC]];
      if (gp_mode[ctrl_q[CTRL_GC0_SRC]]) gclk_tick[0] = 1'b0;
      if (gp_mode[ctrl_q[CTRL_GC1_SRC]]) gclk_tick[1] = 1'b0;
    end else begin
      gclk_tick[0] = ded_rise[0] & ~gp_mode[0];
      gclk_tick[1] = gclk_tick[0];
    end
  end

  // A dedicated line in general use no longer acts as a control
  assign gclr_low = ded_s[2] | gp_mode[2];

  // Term array input: routing bus, general dedicated lines, expanders
  logic [NUM_DED-1:0] ded_gp;
  logic [NUM_MC-1:0] exp_term, cell_out;
  logic [ARR_W-1:0] arr;

  assign ded_gp = ded_s & gp_mode;
  // Expanders return inverted; every cell sees all of them
  assign arr = {~exp_term, ded_gp, route_s};

  // Sixteen cells sharing one array and one expander pool
  genvar m;
  generate
    for (m = 0; m < NUM_MC; m++) begin : g_mc
      logic [NUM_PT*ARR_W-1:0] tm, cm;
      for (genvar t = 0; t < NUM_PT; t++) begin : g_t
        assign tm[t*ARR_W +: ARR_W] = pt_true_q[m*NUM_PT+t];
        assign cm[t*ARR_W +: ARR_W] = pt_comp_q[m*NUM_PT+t];
      end
      // Five own terms plus sixteen shared stay under the 32 limit
      pld_macrocell u_mc (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_run(running),
        .i_cfg(mc_cfg_q[m]),
        .i_tmask(tm),
        .i_cmask(cm),
        .i_arr(arr),
        .i_gclk_tick(gclk_tick),
        .i_gclr_low(gclr_low),
        .i_fast_pin(pin_s[m] & EXTENDED),
        .o_out(cell_out[m]),
        .o_exp(exp_term[m])
      );
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_srst) o_mc_out <= '0;
    else o_mc_out <= cell_out;
  end

  // Output enable 0, and enable 1 without EXTENDED, follow active-low pins unless used as general inputs
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_oe <= '0;
    end else begin
      o_oe[0] <= ~ded_s[3] & ~gp_mode[3];
      o_oe[1] <= EXTENDED ? 1'b0 : (~ded_s[1] & ~gp_mode[1]);
    end
  end

  // APB slave: one wait state, answer on the second access cycle
  region_t region;
  logic access, commit, cfg_region, refused;
  logic [31:0] rd_data;
  logic [6:0] pt_idx;
  logic [1:0] pt_word;
  logic [3:0] mc_idx;
  logic [ADDR_W-1:0] pt_off;

  assign region = region_of(i_paddr);
  assign access = i_psel & i_penable;
  assign commit = access & o_pready;
  assign pt_off = i_paddr - ADDR_PT_BASE;
  assign pt_idx = pt_off[10:4];
  assign pt_word = pt_off[3:2];
  assign mc_idx = i_paddr[5:2];
  assign cfg_region = (region == R_MC) || (region == R_PT);
  // Changing the personality while running is refused
  assign refused = (region == R_NONE) |
                   (i_pwrite & cfg_region & running);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (region)
      R_CTRL: rd_data[CTRL_W-1:0] = ctrl_q;
      R_STAT: rd_data = {12'h000, ded_s, o_mc_out};
      R_MC: rd_data[MC_CFG_W-1:0] = mc_cfg_q[mc_idx];
      R_PT: begin
        case (pt_word)
          2'd0: rd_data = pt_true_q[pt_idx][31:0];
          2'd1: rd_data[ARR_W-33:0] = pt_true_q[pt_idx][ARR_W-1:32];
          2'd2: rd_data = pt_comp_q[pt_idx][31:0];
          default: rd_data[ARR_W-33:0] = pt_comp_q[pt_idx][ARR_W-1:32];
        endcase
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= access & ~o_pready;
      if (access & ~o_pready) begin
        o_pslverr <= refused;
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
      end else begin
        o_pslverr <= 1'b0;
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) ctrl_q <= CTRL_RESET;
    else if (commit && i_pwrite && region == R_CTRL)
      ctrl_q <= i_pwdata[CTRL_W-1:0];
  end

  // Per-cell personality: type, bypass, clock mode, clear, matrix
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_MC; i++) mc_cfg_q[i] <= MC_CFG_RESET;
    end else if (commit && i_pwrite && region == R_MC && !running) begin
      mc_cfg_q[mc_idx] <= i_pwdata[MC_CFG_W-1:0];
    end
  end

  // Term literal masks, loaded only while the group is stopped
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_TERMS; i++) begin
        pt_true_q[i] <= '0;
        pt_comp_q[i] <= '0;
      end
    end else if (commit && i_pwrite && region == R_PT && !running) begin
      case (pt_word)
        2'd0: pt_true_q[pt_idx][31:0] <= i_pwdata;
        2'd1: pt_true_q[pt_idx][ARR_W-1:32] <= i_pwdata[ARR_W-33:0];
        2'd2: pt_comp_q[pt_idx][31:0] <= i_pwdata;
        default: pt_comp_q[pt_idx][ARR_W-1:32] <= i_pwdata[ARR_W-33:0];
      endcase
    end
  end

endmodule

// ---- tb/pld_group_chk_sva.sv ----
// Concurrent checks on the logic group's ports
`timescale 1ns/100ps
module pld_group_chk
  import pld_pkg::*;
#(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pld_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [pld_pkg::NUM_MC-1:0] o_mc_out,
  input wire logic [1:0] o_oe
);
  logic run_q;
  logic ctrl_wr;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  assign ctrl_wr = o_pready && !o_pslverr && i_pwrite && i_paddr == ADDR_CTRL;

  // Shadow of the run bit, so locked writes can be recognised
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      run_q <= 1'b0;
    end else if (ctrl_wr) begin
      run_q <= i_pwdata[CTRL_RUN];
    end
  end

  a_ready_wait: assert property ((i_psel && !i_penable) ##1
    (i_psel && i_penable) |=> o_pready) else $error("late pready");
  a_ready_cause: assert property (o_pready |->
    $past(i_psel) && $past(i_penable)) else $error("stray pready");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  a_err_alone: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!o_pready |->
    o_prdata == 32'h0000_0000) else $error("prdata not idle");
  a_unmapped_err: assert property (o_pready &&
    i_paddr == 16'h0008 |-> o_pslverr) else $error("unmapped accepted");
  a_cfg_locked: assert property (o_pready && i_pwrite && run_q &&
    i_paddr >= ADDR_MC_BASE && i_paddr < ADDR_PT_END |-> o_pslverr)
    else $error("write while running accepted");
  a_reset_out: assert property ($fell(i_srst) |->
    o_mc_out == 16'h0000 && !o_pready) else $error("outputs after reset");
  a_oe_extended: assert property (EXTENDED |-> o_oe[1] == 1'b0)
    else $error("second enable active");
endmodule

bind pld_logic_group pld_group_chk #(.EXTENDED(EXTENDED)) i_pld_group_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_mc_out(o_mc_out), .o_oe(o_oe)
);

// ---- tb/pin_side_model.sv ----
// Model of the pins and routing bus facing the logic group
`timescale 1ns/100ps
module pin_side_model (
  input wire logic i_mclk,
  input wire logic [35:0] i_route,
  input wire logic i_pulse,
  output logic [35:0] o_route,
  output logic o_clk_a
);
  int cnt = 0;

  initial begin
    o_route = 36'h0_0000_0000;
    o_clk_a = 1'b0;
  end

  // Clock pin rests low between pulses; each pulse holds it high for four cycles
  always @(posedge i_mclk) begin
    o_route <= i_route;
    if (i_pulse && cnt == 0) begin
      cnt <= 8;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    o_clk_a <= (cnt > 4);
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the logic group
`timescale 1ns/100ps
module testbench;
  import pld_pkg::*;
  logic mclk, srst, psel, penable, pwrite, pulse, clr_low, clk_a, er;
  logic oe_low;
  logic [15:0] paddr, mc_out, em;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  logic [35:0] route, bus;
  logic [1:0] oe;
  logic [15:0] cfg_a [15] = '{16'h0100, 16'h1000, 16'h0104, 16'h1050,
    16'h0108, 16'h10A0, 16'h10B0, 16'h010C, 16'h10F0, 16'h0110,
    16'h1144, 16'h0114, 16'h1194, 16'h0118, 16'h11E0};
  logic [31:0] cfg_d [15] = '{32'h0000_0204, 32'h0000_0008,
    32'h0000_0240, 32'h0000_0010, 32'h0000_5208, 32'h0000_0010,
    32'h0000_0020, 32'h0000_0C00, 32'h0000_0040, 32'h0000_0204,
    32'h0000_0800, 32'h0000_0204, 32'h0000_0800, 32'h0000_0600,
    32'h0000_0080};
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  pld_logic_group i_pld_logic_group (.i_mclk(mclk), .i_srst(srst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_global_routing_bus(bus),
    .i_global_clock_pin_a(clk_a), .i_global_clock_pin_b(1'b0),
    .i_global_clear_low(clr_low), .i_oe_low(oe_low), .i_pin(16'h0000),
    .o_mc_out(mc_out), .o_oe(oe));
  pin_side_model i_pin_side_model (.i_mclk(mclk), .i_route(route),
    .i_pulse(pulse), .o_route(bus), .o_clk_a(clk_a));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole run needs about two hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pready is read at the rising edge, before that edge's updates land
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rt(input int b, input logic v);
    route[b] <= v;
    repeat (6) @(posedge mclk);
  endtask

  task automatic tick;
    pulse <= 1'b1;
    @(posedge mclk);
    pulse <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask

  task automatic t_setup;
    apb(1'b0, 16'h011C, 32'h0);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, cfg_a[i], cfg_d[i]);
      chk(32'(er), 32'h0);
    end
    apb(1'b0, 16'h0108, 32'h0);
    chk(rd, 32'h0000_5208);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (6) @(posedge mclk);
    em = 16'h0030;
    chk(32'(mc_out), 32'(em));
  endtask

  task automatic t_bypass;
    rt(3, 1'b1);
    chk(32'(mc_out), 32'h0031);
    rt(3, 1'b0);
    chk(32'(mc_out), 32'h0030);
  endtask

  task automatic t_clock;
    rt(4, 1'b1);
    tick;
    chk(32'(mc_out), 32'h0032);
    rt(5, 1'b1);
    tick;
    em = 16'h0036;
    chk(32'(mc_out), 32'(em));
  endtask

  task automatic t_clear;
    clr_low <= 1'b0;
    repeat (6) @(posedge mclk);
    em = 16'h0034;
    chk(32'(mc_out), 32'(em));
    clr_low <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(mc_out), 32'(em));
  endtask

  task automatic t_share;
    rt(6, 1'b1);
    chk(32'(mc_out), 32'h0004);
    rt(6, 1'b0);
    chk(32'(mc_out), 32'(em));
  endtask

  task automatic t_preset;
    rt(7, 1'b1);
    em = 16'h0074;
    chk(32'(mc_out), 32'(em));
    rt(7, 1'b0);
    chk(32'(mc_out), 32'(em));
  endtask

  task automatic t_lock;
    apb(1'b1, 16'h0100, 32'h0000_0000);
    chk(32'(er), 32'h1);
    apb(1'b0, 16'h0100, 32'h0);
    chk(rd, 32'h0000_0204);
    apb(1'b0, 16'h0008, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, {12'h000, 4'hC, em});
    chk(32'(oe), 32'h0);
    oe_low <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(32'(oe), 32'h1);
    oe_low <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'(oe), 32'h0);
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    route = 36'h0_0000_0000;
    pulse = 1'b0;
    clr_low = 1'b1;
    oe_low = 1'b1;
    em = 16'h0000;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_setup;
    t_bypass;
    t_clock;
    t_clear;
    t_share;
    t_preset;
    t_lock;
    wrap_up;
  end
endmodule
